/* File: core/fpcs_pkg.sv */
/*
  Constants shared by the fast-mode control/status register pair: management
  frame fields, register numbers, control bit positions, reset values and
  indicator stretch timing.
  Assumes a 100 MHz system clock and register numbers as seen on the
  management serial interface.
*/
`default_nettype none

package fpcs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned STRETCH_MIN_MS  = 42;
  // Cycles in one stretch tick; two ticks give the 42 ms to 84 ms window
  localparam int unsigned STRETCH_TICK_CYC_DEF = STRETCH_MIN_MS * (CLK_HZ / 1000);
  localparam logic [1:0]  STRETCH_TICKS   = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Management frame
  localparam logic [1:0]  OP_RD           = 2'h2;
  localparam logic [1:0]  OP_WR           = 2'h1;
  localparam logic [4:0]  HDR_LAST        = 5'h0B;
  localparam logic [4:0]  DATA_LAST       = 5'h0F;
  localparam logic [4:0]  REG_STATUS      = 5'h1C;
  localparam logic [4:0]  REG_CTRL        = 5'h1D;

  ////////////////////////////////////////////////////////////////////////////
  // Status register bits
  localparam int unsigned STS_FAST_UP     = 1;
  localparam int unsigned STS_SLOW_UP     = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Control register bits
  localparam int unsigned CTRL_SOFT_RST   = 15;
  localparam int unsigned CTRL_TEST_A     = 14;
  localparam int unsigned CTRL_TEST_B     = 13;
  localparam int unsigned CTRL_TX_ON      = 12;
  localparam int unsigned CTRL_BIT_A      = 11;
  localparam int unsigned CTRL_CS_SELECT  = 10;
  localparam int unsigned CTRL_LINK_ERR   = 9;
  localparam int unsigned CTRL_PACKET_ERROR_REPORT_EN    = 8;
  localparam int unsigned CTRL_STRETCH    = 7;
  localparam int unsigned CTRL_CODEC_BYP  = 6;
  localparam int unsigned CTRL_ALIGN_BYP  = 5;
  localparam int unsigned CTRL_SCR_BYP    = 4;
  localparam int unsigned CTRL_CARIN      = 3;
  localparam int unsigned CTRL_JAM        = 2;
  localparam int unsigned CTRL_FEF        = 1;
  localparam int unsigned CTRL_FIBER      = 0;
  localparam logic [15:0] CTRL_RST_VAL    = 16'h1000;

  ////////////////////////////////////////////////////////////////////////////
  // Receive error codes placed on the nibble bus
  localparam logic [3:0]  LINK_ERR_CODE_DEF = 4'h1;
  localparam logic [3:0]  PACKET_ERROR_REPORT_EN_CODE_DEF  = 4'h2;

  typedef enum logic [2:0] {
    MS_IDLE,
    MS_START,
    MS_HDR,
    MS_TA,
    MS_DATA
  } fpcs_mdio_st_t;

endpackage

`default_nettype wire

/* File: core/fpcs_tick.sv */
/*
  Free-running divider giving a one-cycle enable pulse every DIV cycles.
  Assumes DIV is at least 2.
*/
`default_nettype none

module fpcs_tick #(
  parameter int unsigned DIV = 4
) (
  // Clock and reset
  input  wire logic CLK_SYS,
  input  wire logic NRST,
  // Enable pulse
  output logic      TICK
);

  localparam int unsigned CW = $clog2(DIV);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } fpcs_tick_st_t;

  fpcs_tick_st_t st_ff;
  fpcs_tick_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'h0;
    if (st_ff.cnt == CW'(DIV - 1)) begin
      nxt_st.cnt  = '0;
      nxt_st.tick = 1'h1;
    end else begin
      nxt_st.cnt = st_ff.cnt + CW'(1);
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign TICK = st_ff.tick;

endmodule // fpcs_tick

`default_nettype wire

/* File: core/fpcs_stretch.sv */
/*
  Indicator pulse stretcher: while enabled, the output holds for two ticks
  of the stretch divider after the input falls.
  Assumes TICK is a one-cycle pulse from fpcs_tick.
*/
`default_nettype none

module fpcs_stretch (
  // Clock and reset
  input  wire logic CLK_SYS,
  input  wire logic NRST,
  // Control
  input  wire logic TICK,
  input  wire logic EN,
  // Indicator
  input  wire logic SIG_IN,
  output logic      SIG_OUT
);
  import fpcs_pkg::*;

  typedef struct packed {
    logic [1:0] hold;
    logic       out;
  } fpcs_str_st_t;

  fpcs_str_st_t st_ff;
  fpcs_str_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    // Partial first tick makes the window 42 to 84 ms rather than exact
    if (SIG_IN) begin
      nxt_st.hold = STRETCH_TICKS;
    end else if (TICK && st_ff.hold != 2'h0) begin
      nxt_st.hold = st_ff.hold - 2'h1;
    end
    nxt_st.out = SIG_IN || (EN && st_ff.hold != 2'h0);
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign SIG_OUT = st_ff.out;

  str_follow_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    !EN && !SIG_IN |=> !SIG_OUT)
    else $error("indicator held while stretching disabled");
  str_hold_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    EN && $fell(SIG_IN) && !TICK |=> SIG_OUT)
    else $error("indicator not stretched after input fell");

endmodule // fpcs_stretch

`default_nettype wire

/* File: core/fpcs_ctrl_status.sv */
/*
  Per-port fast-mode control register and link-up status register, reached
  by management frames on MDC/MDIO, with the port controls they drive.
  Assumes MDC and all pins are synchronous to CLK_SYS and MDC runs at most
  at one quarter of CLK_SYS. Other registers of the port answer elsewhere.
*/
`default_nettype none

// What this block does
// - Status bit 28.1 reads 1 while the fast transceiver is up, read-only.
// - Status bit 28.0 reads 1 while the slow transceiver is up, read-only.
// - Writing 1 to 29.15 resets registers 0-15, 28 and 29 to defaults.
// - The soft reset bit clears itself after the reset is applied.
// - Bits 29.14 and 29.13 are test-only; stored and driven out on TEST_RESET_A and TEST_RESET_B.
// - With 29.12 at 0 the pair outputs go positive low, negative high; default 1.
// - LED blinking is on when 29.11 or the blink input is 1; default 0.
// - Carrier sense select 1 means receive only; 0 means receive or transmit.
// - Effective carrier sense select is 29.10 ORed with its pin.
// - With 29.9 set, a link error code goes on the nibble bus on errors.
// - With 29.8 set, a scrambler-unlocked code goes on the nibble bus on errors.
// - With 29.7 set, collision, transmit and receive indicators stretch 42-84 ms.
// - Codec bypass is 29.6 ORed with its pin.
// - Aligner bypass follows 29.5.
// - Scrambler bypass is 29.4 ORed with its pin.
// - Carrier integrity monitor is on with 29.3 or its pin.
// - With 29.2 set, carrier integrity jam is ORed into collision sense.
// - Far-end fault runs when 29.1 is 1; default 0.
// - Fiber mode is 29.0 ORed with its pin.
module fpcs_ctrl_status #(
  parameter int unsigned STRETCH_TICK_CYC = fpcs_pkg::STRETCH_TICK_CYC_DEF,
  parameter logic [3:0]  LINK_ERR_CODE    = fpcs_pkg::LINK_ERR_CODE_DEF,
  parameter logic [3:0]  PACKET_ERROR_REPORT_EN_CODE     = fpcs_pkg::PACKET_ERROR_REPORT_EN_CODE_DEF
) (
  // Clock and reset
  input  wire logic       CLK_SYS,
  input  wire logic       NRST,
  // Management serial interface
  input  wire logic       MDC,
  input  wire logic       MDIO_IN,
  output logic            MDIO_OUT,
  output logic            MDIO_OE,
  input  wire logic [4:0] PHY_ADDR,
  // Link state
  input  wire logic       FAST_LINK_UP,
  input  wire logic       SLOW_LINK_UP,
  // Reset controls
  output logic            MGMT_SOFT_RESET,
  output logic            TEST_RESET_A,
  output logic            TEST_RESET_B,
  // Twisted-pair transmit
  input  wire logic       TX_POS_IN,
  input  wire logic       TX_NEG_IN,
  output logic            TP_OUT_POS,
  output logic            TP_OUT_NEG,
  // Carrier and collision
  input  wire logic       CARRIER_SENSE_SELECT_PIN,
  input  wire logic       RX_ACTIVE,
  input  wire logic       TX_ACTIVE,
  input  wire logic       COLLISION_IN,
  input  wire logic       JAM_IN,
  output logic            CARRIER_SENSE_OUT,
  output logic            COLLISION_SENSE_OUT,
  // Receive nibble bus
  input  wire logic [3:0] RX_NIBBLE_IN,
  input  wire logic       RX_ERROR_IN,
  input  wire logic       LINK_ERROR_IN,
  input  wire logic       SCRAMBLER_UNLOCKED_IN,
  output logic [3:0]      RX_NIBBLE_BUS,
  output logic            RX_ERROR_OUT,
  // Indicators
  input  wire logic       BIT_A_INPUT,
  output logic            BLINK_ENABLE,
  output logic            COLLISION_INDICATOR,
  output logic            TRANSMIT_INDICATOR,
  output logic            RECEIVE_INDICATOR,
  // Datapath modes
  input  wire logic       CODEC_BYPASS_PIN,
  input  wire logic       SCRAMBLER_BYPASS_PIN,
  input  wire logic       CARRIER_INTEGRITY_PIN,
  input  wire logic       FIBER_MODE_PIN,
  output logic            CODEC_BYPASS,
  output logic            ALIGNER_BYPASS,
  output logic            SCRAMBLER_BYPASS,
  output logic            CARRIER_INTEGRITY_EN,
  output logic            FAR_END_FAULT_EN,
  output logic            FIBER_MODE
);
  import fpcs_pkg::*;

  typedef struct packed {
    fpcs_mdio_st_t ms;
    logic          mdc_q;
    logic          pre;
    logic [4:0]    cnt;
    logic [11:0]   hdr;
    logic [15:0]   sr;
    logic          rd_hit;
    logic          wr_hit;
    logic          mdio_out;
    logic          mdio_oe;
    logic [15:0]   ctrl;
    logic          soft_rst;
    logic          tp_pos;
    logic          tp_neg;
    logic          crs;
    logic          col_sense;
    logic [3:0]    rx_nib;
    logic          rx_er;
  } fpcs_main_st_t;

  localparam fpcs_main_st_t ST_RST = '{
    ms: MS_IDLE, mdc_q: 1'h0, pre: 1'h0, cnt: 5'h00, hdr: 12'h000,
    sr: 16'h0000, rd_hit: 1'h0, wr_hit: 1'h0, mdio_out: 1'h0,
    mdio_oe: 1'h0, ctrl: CTRL_RST_VAL, soft_rst: 1'h0, tp_pos: 1'h0,
    tp_neg: 1'h1, crs: 1'h0, col_sense: 1'h0, rx_nib: 4'h0, rx_er: 1'h0};

  fpcs_main_st_t st_ff;
  fpcs_main_st_t nxt_st;

  logic        mdc_rise;
  logic        hdr_done;
  logic [11:0] hdr_word;
  logic        wr_now;
  logic [15:0] wr_word;
  logic        cs_sel_eff;
  logic        tick;

  ////////////////////////////////////////////////////////////////////////////
  // Management frames and register file

  assign mdc_rise = MDC && !st_ff.mdc_q;
  assign hdr_word = {st_ff.hdr[10:0], MDIO_IN};
  assign hdr_done = mdc_rise && st_ff.ms == MS_HDR && st_ff.cnt == HDR_LAST;
  assign wr_word  = {st_ff.sr[14:0], MDIO_IN};
  assign wr_now   = mdc_rise && st_ff.ms == MS_DATA && st_ff.cnt == DATA_LAST
                    && st_ff.wr_hit;
  assign cs_sel_eff = st_ff.ctrl[CTRL_CS_SELECT] || CARRIER_SENSE_SELECT_PIN;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.mdc_q    = MDC;
    nxt_st.soft_rst = 1'h0;
    if (mdc_rise) begin
      case (st_ff.ms)
        MS_IDLE: begin
          // Short preamble accepted: any run of ones before the start bit
          if (MDIO_IN) begin
            nxt_st.pre = 1'h1;
          end else if (st_ff.pre) begin
            nxt_st.ms = MS_START;
          end
        end
        MS_START: begin
          nxt_st.pre = 1'h0;
          nxt_st.cnt = 5'h00;
          nxt_st.ms  = MDIO_IN ? MS_HDR : MS_IDLE;
        end
        MS_HDR: begin
          nxt_st.hdr = hdr_word;
          nxt_st.cnt = st_ff.cnt + 5'h01;
          if (hdr_done) begin
            nxt_st.ms  = MS_TA;
            nxt_st.cnt = 5'h00;
            nxt_st.rd_hit = hdr_word[11:10] == OP_RD && hdr_word[9:5] == PHY_ADDR
                            && (hdr_word[4:0] == REG_STATUS
                                || hdr_word[4:0] == REG_CTRL);
            nxt_st.wr_hit = hdr_word[11:10] == OP_WR && hdr_word[9:5] == PHY_ADDR
                            && hdr_word[4:0] == REG_CTRL;
            // Read data is captured here so the word is coherent
            if (hdr_word[4:0] == REG_STATUS) begin
              nxt_st.sr = 16'h0000;
              nxt_st.sr[STS_FAST_UP] = FAST_LINK_UP;
              nxt_st.sr[STS_SLOW_UP] = SLOW_LINK_UP;
            end else begin
              nxt_st.sr = st_ff.ctrl;
            end
          end
        end
        MS_TA: begin
          nxt_st.cnt = st_ff.cnt + 5'h01;
          if (st_ff.cnt == 5'h00) begin
            // First turnaround bit left to the controller, second driven 0
            nxt_st.mdio_oe  = st_ff.rd_hit;
            nxt_st.mdio_out = 1'h0;
          end else begin
            nxt_st.ms       = MS_DATA;
            nxt_st.cnt      = 5'h00;
            nxt_st.mdio_out = st_ff.sr[15];
            nxt_st.sr       = wr_word;
          end
        end
        MS_DATA: begin
          nxt_st.cnt      = st_ff.cnt + 5'h01;
          nxt_st.mdio_out = st_ff.sr[15];
          nxt_st.sr       = wr_word;
          if (st_ff.cnt == DATA_LAST) begin
            nxt_st.ms       = MS_IDLE;
            nxt_st.mdio_oe  = 1'h0;
            nxt_st.mdio_out = 1'h0;
            nxt_st.rd_hit   = 1'h0;
            nxt_st.wr_hit   = 1'h0;
          end
        end
        default: begin
          nxt_st.ms = MS_IDLE;
        end
      endcase
    end
    if (wr_now) begin
      if (wr_word[CTRL_SOFT_RST]) begin
        // Whole word dropped: the reset wins over the other written bits
        nxt_st.ctrl     = CTRL_RST_VAL;
        nxt_st.soft_rst = 1'h1;
      end else begin
        nxt_st.ctrl = wr_word;
      end
      nxt_st.ctrl[CTRL_SOFT_RST] = 1'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Port datapath controls
    nxt_st.tp_pos = st_ff.ctrl[CTRL_TX_ON] ? TX_POS_IN : 1'h0;
    nxt_st.tp_neg = st_ff.ctrl[CTRL_TX_ON] ? TX_NEG_IN : 1'h1;
    nxt_st.crs = cs_sel_eff ? RX_ACTIVE : (RX_ACTIVE || TX_ACTIVE);
    nxt_st.col_sense = COLLISION_IN || nxt_st.crs
                       || (st_ff.ctrl[CTRL_JAM] && JAM_IN);
    nxt_st.rx_er  = RX_ERROR_IN;
    nxt_st.rx_nib = RX_NIBBLE_IN;
    if (RX_ERROR_IN) begin
      // Link error code takes precedence when both conditions hold
      if (st_ff.ctrl[CTRL_LINK_ERR] && LINK_ERROR_IN) begin
        nxt_st.rx_nib = LINK_ERR_CODE;
      end else if (st_ff.ctrl[CTRL_PACKET_ERROR_REPORT_EN] && SCRAMBLER_UNLOCKED_IN) begin
        nxt_st.rx_nib = PACKET_ERROR_REPORT_EN_CODE;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indicator stretching

  fpcs_tick #(
    .DIV (STRETCH_TICK_CYC)
  ) u_tick (
    .CLK_SYS (CLK_SYS),
    .NRST    (NRST),
    .TICK    (tick)
  );

  fpcs_stretch u_str_col (
    .CLK_SYS (CLK_SYS),
    .NRST    (NRST),
    .TICK    (tick),
    .EN      (st_ff.ctrl[CTRL_STRETCH]),
    .SIG_IN  (COLLISION_IN),
    .SIG_OUT (COLLISION_INDICATOR)
  );

  fpcs_stretch u_str_tx (
    .CLK_SYS (CLK_SYS),
    .NRST    (NRST),
    .TICK    (tick),
    .EN      (st_ff.ctrl[CTRL_STRETCH]),
    .SIG_IN  (TX_ACTIVE),
    .SIG_OUT (TRANSMIT_INDICATOR)
  );

  fpcs_stretch u_str_rx (
    .CLK_SYS (CLK_SYS),
    .NRST    (NRST),
    .TICK    (tick),
    .EN      (st_ff.ctrl[CTRL_STRETCH]),
    .SIG_IN  (RX_ACTIVE),
    .SIG_OUT (RECEIVE_INDICATOR)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign MDIO_OUT             = st_ff.mdio_out;
  assign MDIO_OE              = st_ff.mdio_oe;
  assign MGMT_SOFT_RESET      = st_ff.soft_rst;
  assign TEST_RESET_A         = st_ff.ctrl[CTRL_TEST_A];
  assign TEST_RESET_B         = st_ff.ctrl[CTRL_TEST_B];
  assign TP_OUT_POS           = st_ff.tp_pos;
  assign TP_OUT_NEG           = st_ff.tp_neg;
  assign CARRIER_SENSE_OUT    = st_ff.crs;
  assign COLLISION_SENSE_OUT  = st_ff.col_sense;
  assign RX_NIBBLE_BUS        = st_ff.rx_nib;
  assign RX_ERROR_OUT         = st_ff.rx_er;
  assign BLINK_ENABLE         = st_ff.ctrl[CTRL_BIT_A] || BIT_A_INPUT;
  assign CODEC_BYPASS         = st_ff.ctrl[CTRL_CODEC_BYP] || CODEC_BYPASS_PIN;
  assign ALIGNER_BYPASS       = st_ff.ctrl[CTRL_ALIGN_BYP];
  assign SCRAMBLER_BYPASS     = st_ff.ctrl[CTRL_SCR_BYP] || SCRAMBLER_BYPASS_PIN;
  assign CARRIER_INTEGRITY_EN = st_ff.ctrl[CTRL_CARIN] || CARRIER_INTEGRITY_PIN;
  assign FAR_END_FAULT_EN     = st_ff.ctrl[CTRL_FEF];
  assign FIBER_MODE           = st_ff.ctrl[CTRL_FIBER] || FIBER_MODE_PIN;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);

  status_read_a: assert property (
    hdr_done && hdr_word[11:10] == OP_RD && hdr_word[9:5] == PHY_ADDR
    && hdr_word[4:0] == REG_STATUS
    |=> st_ff.sr == {14'h0000, $past(FAST_LINK_UP), $past(SLOW_LINK_UP)})
    else $error("status word not captured from link-up inputs");
  soft_reset_a: assert property (
    wr_now && wr_word[CTRL_SOFT_RST]
    |=> MGMT_SOFT_RESET && st_ff.ctrl == CTRL_RST_VAL ##1 !MGMT_SOFT_RESET)
    else $error("soft reset did not restore control defaults once");
  ctrl_write_a: assert property (
    wr_now && !wr_word[CTRL_SOFT_RST] |=> st_ff.ctrl == $past(wr_word))
    else $error("control write not stored");
  tx_force_a: assert property (
    !st_ff.ctrl[CTRL_TX_ON] |=> !TP_OUT_POS && TP_OUT_NEG)
    else $error("pair outputs not forced while transmitter off");
  crs_rx_only_a: assert property (
    (st_ff.ctrl[CTRL_CS_SELECT] || CARRIER_SENSE_SELECT_PIN) && TX_ACTIVE
    && !RX_ACTIVE |=> !CARRIER_SENSE_OUT)
    else $error("carrier sense raised on transmit in receive-only mode");
  crs_tx_a: assert property (
    !st_ff.ctrl[CTRL_CS_SELECT] && !CARRIER_SENSE_SELECT_PIN && TX_ACTIVE
    |=> CARRIER_SENSE_OUT)
    else $error("carrier sense missing on transmit");
  link_code_a: assert property (
    RX_ERROR_IN && st_ff.ctrl[CTRL_LINK_ERR] && LINK_ERROR_IN
    |=> RX_ERROR_OUT && RX_NIBBLE_BUS == LINK_ERR_CODE)
    else $error("link error code not reported");
  pkt_code_a: assert property (
    RX_ERROR_IN && !(st_ff.ctrl[CTRL_LINK_ERR] && LINK_ERROR_IN)
    && st_ff.ctrl[CTRL_PACKET_ERROR_REPORT_EN] && SCRAMBLER_UNLOCKED_IN
    |=> RX_NIBBLE_BUS == PACKET_ERROR_REPORT_EN_CODE)
    else $error("packet error code not reported");
  nibble_pass_a: assert property (
    !RX_ERROR_IN |=> RX_NIBBLE_BUS == $past(RX_NIBBLE_IN))
    else $error("nibble altered without receive error");
  jam_merge_a: assert property (
    st_ff.ctrl[CTRL_JAM] && JAM_IN |=> COLLISION_SENSE_OUT)
    else $error("jam not merged into collision sense");

endmodule // fpcs_ctrl_status

`default_nettype wire

/* File: dv/fpcs_mgmt_model.sv */
/*
  Management station model: clocks MDC only inside frames and shifts
  read and write frames onto the shared data line.
  Assumes a pull-up on that line and a CLK_SYS-synchronous block.
*/
`default_nettype none

module fpcs_mgmt_model (
  // Clock
  input  wire logic CLK_SYS,
  // Management lines
  output logic      MDC,
  output logic      MDIO_LINE,
  input  wire logic MDIO_OUT,
  input  wire logic MDIO_OE
);
  timeunit 1ns;
  timeprecision 1ps;

  logic drv_oe = 1'b0;
  logic drv_d  = 1'b0;

  initial MDC = 1'b0;

  // A released line floats up, so a stale value is never seen
  assign MDIO_LINE = MDIO_OE ? MDIO_OUT : (drv_oe ? drv_d : 1'b1);

  // MDC period of five system cycles keeps inside the quarter-rate limit
  task automatic mbit(input logic oe, input logic b, output logic s);
    @(posedge CLK_SYS);
    MDC    <= 1'b0;
    drv_oe <= oe;
    drv_d  <= b;
    repeat (2) @(posedge CLK_SYS);
    @(negedge CLK_SYS);
    s = MDIO_LINE;
    @(posedge CLK_SYS);
    MDC <= 1'b1;
    @(posedge CLK_SYS);
  endtask

  task automatic frame(input logic [1:0] op, input logic [4:0] rg, input logic [4:0] phy,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [33:0] f;
    logic        s;
    // Two preamble ones, then start 0 1; the block needs a one before the start bit
    f = {4'b1101, op, phy, rg, 2'b10, wd};
    for (int i = 33; i >= 0; i--) begin
      mbit(op == fpcs_pkg::OP_WR || i > 17, f[i], s);
      if (i < 16) rd[i] = s;
    end
    @(posedge CLK_SYS);
    MDC    <= 1'b0;
    drv_oe <= 1'b0;
  endtask

endmodule // fpcs_mgmt_model

`default_nettype wire

/* File: dv/fpcs_ctrl_status_tb.sv */
/*
  Self-checking bench for the fast-mode control/status registers.
  Assumes the management model drives MDC and MDIO; pins are random.
*/
`default_nettype none

module fpcs_ctrl_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fpcs_pkg::*;

  localparam logic [4:0] PA = 5'h05;

  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [20:0] pins = '0;
  wire         mdc, line, mo, moe, srst;
  wire  [2:0]  ind;
  wire  [17:0] obs;
  logic [15:0] ctrl, v;
  int          err_count = 0;
  int          compares = 0;
  int          nsr = 0;
  int          n [3];

  initial begin
    forever #5 clk = ~clk;
  end

  fpcs_mgmt_model mm (.CLK_SYS(clk), .MDC(mdc), .MDIO_LINE(line), .MDIO_OUT(mo), .MDIO_OE(moe));

  fpcs_ctrl_status #(.STRETCH_TICK_CYC(8)) dut (
    .CLK_SYS(clk), .NRST(nrst), .MDC(mdc), .MDIO_IN(line), .MDIO_OUT(mo), .MDIO_OE(moe),
    .PHY_ADDR(PA), .FAST_LINK_UP(pins[0]), .SLOW_LINK_UP(pins[1]),
    .MGMT_SOFT_RESET(srst), .TEST_RESET_A(obs[17]), .TEST_RESET_B(obs[16]),
    .TX_POS_IN(pins[2]), .TX_NEG_IN(pins[3]), .TP_OUT_POS(obs[15]), .TP_OUT_NEG(obs[14]),
    .CARRIER_SENSE_SELECT_PIN(pins[4]), .RX_ACTIVE(pins[5]), .TX_ACTIVE(pins[6]),
    .COLLISION_IN(pins[7]), .JAM_IN(pins[8]), .CARRIER_SENSE_OUT(obs[13]),
    .COLLISION_SENSE_OUT(obs[12]), .RX_NIBBLE_IN(pins[12:9]), .RX_ERROR_IN(pins[13]),
    .LINK_ERROR_IN(pins[14]), .SCRAMBLER_UNLOCKED_IN(pins[15]), .RX_NIBBLE_BUS(obs[11:8]),
    .RX_ERROR_OUT(obs[7]), .BIT_A_INPUT(pins[16]), .BLINK_ENABLE(obs[6]),
    .COLLISION_INDICATOR(ind[0]), .TRANSMIT_INDICATOR(ind[1]), .RECEIVE_INDICATOR(ind[2]),
    .CODEC_BYPASS_PIN(pins[17]), .SCRAMBLER_BYPASS_PIN(pins[18]),
    .CARRIER_INTEGRITY_PIN(pins[19]), .FIBER_MODE_PIN(pins[20]), .CODEC_BYPASS(obs[5]),
    .ALIGNER_BYPASS(obs[4]), .SCRAMBLER_BYPASS(obs[3]), .CARRIER_INTEGRITY_EN(obs[2]),
    .FAR_END_FAULT_EN(obs[1]), .FIBER_MODE(obs[0]));

  // Counted on the falling edge, away from the edge that moves the pulse
  always @(negedge clk) begin
    if (srst === 1'b1) nsr++;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [17:0] exp_out(logic [15:0] c, logic [20:0] p);
    logic       crs;
    logic [3:0] nib;
    crs = (c[10] | p[4]) ? p[5] : (p[5] | p[6]);
    nib = p[12:9];
    if (p[13] && c[9] && p[14]) nib = LINK_ERR_CODE_DEF;
    else if (p[13] && c[8] && p[15]) nib = PACKET_ERROR_REPORT_EN_CODE_DEF;
    return {c[14:13], c[12] ? {p[2], p[3]} : 2'b01, crs,
            p[7] | crs | (c[2] & p[8]), nib, p[13], c[11] | p[16],
            c[6] | p[17], c[5], c[4] | p[18], c[3] | p[19],
            c[1], c[0] | p[20]};
  endfunction

  task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rd(input logic [4:0] r, output logic [15:0] d);
    mm.frame(OP_RD, r, PA, 16'h0000, d);
  endtask

  task automatic wr(input logic [4:0] r, input logic [4:0] phy, input logic [15:0] d);
    logic [15:0] dummy;
    mm.frame(OP_WR, r, phy, d, dummy);
  endtask

  task automatic end_sim;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    end_sim();
  end

  initial begin
    void'($urandom(73376));
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    ctrl = CTRL_RST_VAL;
    rd(REG_CTRL, v);
    chk("ctrl_reset", 18'(ctrl), 18'(v));
    // Autonegotiation is never on here, so far-end fault may be set
    for (int k = 0; k < 16; k++) begin
      ctrl = (k == 0) ? 16'h1FFF : (k == 1) ? 16'h0000 : 16'($urandom) & 16'h1FFF;
      @(posedge clk);
      pins <= 21'($urandom);
      wr(REG_CTRL, PA, ctrl);
      rd(REG_CTRL, v);
      chk("ctrl", 18'(ctrl), 18'(v));
      rd(REG_STATUS, v);
      chk("status", {16'h0000, pins[0], pins[1]}, 18'(v));
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("outputs", exp_out(ctrl, pins), obs);
    end
    wr(REG_STATUS, PA, 16'hFFFF);
    wr(REG_CTRL, 5'h06, 16'h0FFF);
    rd(REG_CTRL, v);
    chk("refused_write", 18'(ctrl), 18'(v));
    rd(5'h1E, v);
    chk("unmapped_read", 18'h0FFFF, 18'(v));
    wr(REG_CTRL, PA, 16'hEFFF);
    rd(REG_CTRL, v);
    chk("soft_reset_ctrl", 18'(CTRL_RST_VAL), 18'(v));
    chk("soft_reset_pulse", 18'd1, 18'(nsr));
    for (int m = 0; m < 2; m++) begin
      wr(REG_CTRL, PA, m ? 16'h1000 : 16'h1080);
      pins <= '0;
      repeat (4) @(posedge clk);
      pins <= 21'h0000E0;
      @(posedge clk);
      pins <= '0;
      n = '{0, 0, 0};
      repeat (40) begin
        @(negedge clk);
        for (int j = 0; j < 3; j++) n[j] += (ind[j] === 1'b1);
      end
      for (int j = 0; j < 3; j++) begin
        chk("stretch", 18'd1, 18'(m ? n[j] == 1 : (n[j] >= 8 && n[j] <= 18)));
      end
    end
    end_sim();
  end

endmodule // fpcs_ctrl_status_tb

`default_nettype wire
